// [cpu_alu_status_muldiv.sv]
// CPU ALU with status/control registers, 17x17 multiplier and iterative divider.
// Assumes the decoder issues one command per cycle and waits on o_div_busy.
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
module cpu_alu_status_muldiv
	import alu_pkg::*;
(
	input  wire logic         i_clock,
	input  wire logic         i_arst_n,
	input  wire logic         i_enable,
	input  wire logic [1:0]   i_avs_address,
	input  wire logic         i_avs_read,
	input  wire logic         i_avs_write,
	input  wire logic [31:0]  i_avs_writedata,
	output logic      [31:0]  o_avs_readdata,
	output logic              o_avs_waitrequest,
	input  wire logic         i_nesting_disable,
	input  wire logic         i_repeat_active,
	input  wire logic         i_prio_load,
	input  wire logic [3:0]   i_prio_value,
	input  wire logic         i_alu_valid,
	input  wire alu_cmd_t     i_alu_cmd,
	input  wire logic         i_carry_in,
	input  wire logic [15:0]  i_mem_rdata,
	output logic      [15:0]  o_mem_wdata,
	output logic              o_mem_we,
	input  wire logic         i_mul_valid,
	input  wire mul_mode_t    i_mul_mode,
	input  wire logic [15:0]  i_mul_a,
	input  wire logic [15:0]  i_mul_b,
	output logic      [31:0]  o_mul_product,
	input  wire logic         i_div_start,
	input  wire div_cmd_t     i_div_cmd,
	input  wire logic         i_div_hold,
	input  wire logic         i_reg_we,
	input  wire logic [3:0]   i_reg_waddr,
	input  wire logic [15:0]  i_reg_wdata,
	output logic      [15:0]  o_reg_dump,
	input  wire logic [3:0]   i_reg_dump_sel,
	output logic              o_div_busy,
	output logic              o_div_done,
	output logic [3:0]        o_cpu_priority,
	output logic              o_user_irq_off,
	output logic              o_program_window
);
	logic [15:0]  wreg [16];
	logic         half_carry, neg, ovf, zero, carry, prio_high, pwin;
	logic [2:0]   prio;
	logic         repeat_s1, repeat_s2;
	logic [15:0]  opa, opb, opb_x, res;
	logic [16:0]  sum;
	logic         c_half, c_out, v_out, is_arith, is_sub;
	logic [33:0]  prod;
	logic signed [16:0] ma, mb;
	div_state_t   div_state;
	logic [4:0]   div_cnt;
	logic [31:0]  div_q;
	logic [16:0]  div_r;
	logic [15:0]  div_d;
	logic         div_neg_q, div_neg_r;
	logic [16:0]  next_r;
	logic         bus_ack;
	logic [15:0]  status_word, control_word;

	// Repeat flag comes from the sequencer, kept on a synchroniser for safety
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			repeat_s1 <= 1'b0;
			repeat_s2 <= 1'b0;
		end else if (i_enable) begin
			repeat_s1 <= i_repeat_active;
			repeat_s2 <= repeat_s1;
		end
	end

	assign status_word = {7'h00, half_carry, prio, repeat_s2, neg, ovf, zero, carry};
	assign control_word = {12'h000, prio_high, pwin, 2'b00};
	assign o_cpu_priority = {prio_high, prio};
	assign o_user_irq_off = prio_high || (prio == PRIO_USER_OFF);
	assign o_program_window = pwin;

	// Operand select by addressing mode
	always_comb begin
		opa = wreg[i_alu_cmd.src_a];
		opb = i_alu_cmd.from_mem ? i_mem_rdata : wreg[i_alu_cmd.src_b];
		if (i_alu_cmd.byte_mode) begin
			opa = {8'h00, opa[7:0]};
			opb = {8'h00, opb[7:0]};
		end
	end

	always_comb begin
		is_sub = (i_alu_cmd.op == OP_SUB) || (i_alu_cmd.op == OP_SBB);
		is_arith = is_sub || (i_alu_cmd.op == OP_ADD) || (i_alu_cmd.op == OP_ADC);
		opb_x = is_sub ? ~opb : opb;
		// Byte subtract keeps the top byte clear, else carry out of bit 7 inverts
		if (i_alu_cmd.byte_mode)
			opb_x[15:8] = 8'h00;
		sum = 17'h0_0000;
		c_half = 1'b0;
		c_out = 1'b0;
		v_out = 1'b0;
		res = 16'h0000;
		case (i_alu_cmd.op)
			OP_ADD, OP_ADC, OP_SUB, OP_SBB: begin
				// Subtract as a plus ~b plus 1, so carry reads as not-borrow
				sum = {1'b0, opa} + {1'b0, opb_x}
					+ {16'h0000, (i_alu_cmd.op == OP_ADD) ? 1'b0 : (i_alu_cmd.op == OP_SUB) ? 1'b1 : i_carry_in};
				res = sum[15:0];
			end
			OP_AND: res = opa & opb;
			OP_OR:  res = opa | opb;
			OP_XOR: res = opa ^ opb;
			OP_SL:  res = {opa[14:0], 1'b0};
			OP_LSR: res = i_alu_cmd.byte_mode ? {9'h000, opa[7:1]} : {1'b0, opa[15:1]};
			OP_ASR: res = i_alu_cmd.byte_mode ? {8'h00, opa[7], opa[7:1]} : {opa[15], opa[15:1]};
			default: res = opb;
		endcase
		if (is_arith) begin
			// Carries recovered from operand and sum bits
			if (i_alu_cmd.byte_mode) begin
				c_half = opa[4] ^ (is_sub ? ~opb[4] : opb[4]) ^ sum[4];
				c_out = sum[8];
				v_out = (opa[7] == (is_sub ? ~opb[7] : opb[7])) && (sum[7] != opa[7]);
			end else begin
				c_half = opa[8] ^ (is_sub ? ~opb[8] : opb[8]) ^ sum[8];
				c_out = sum[16];
				v_out = (opa[15] == (is_sub ? ~opb[15] : opb[15])) && (sum[15] != opa[15]);
			end
		end else if (i_alu_cmd.op == OP_SL) begin
			c_out = i_alu_cmd.byte_mode ? opa[7] : opa[15];
		end else if (i_alu_cmd.op == OP_LSR || i_alu_cmd.op == OP_ASR) begin
			c_out = opa[0];
		end
		if (i_alu_cmd.byte_mode)
			res = {8'h00, res[7:0]};
	end

	// Multiplier: both operands widened to 17 signed bits
	always_comb begin
		ma = {1'b0, i_mul_a};
		mb = {1'b0, i_mul_b};
		case (i_mul_mode)
			MUL_SS: begin
				ma = {i_mul_a[15], i_mul_a};
				mb = {i_mul_b[15], i_mul_b};
			end
			MUL_SLIT: begin
				ma = {i_mul_a[15], i_mul_a};
				mb = {12'h000, i_mul_b[4:0]};
			end
			MUL_ULIT: mb = {12'h000, i_mul_b[4:0]};
			MUL_US:   mb = {i_mul_b[15], i_mul_b};
			MUL_BB: begin
				ma = {9'h000, i_mul_a[7:0]};
				mb = {9'h000, i_mul_b[7:0]};
			end
			default: begin
				ma = {1'b0, i_mul_a};
				mb = {1'b0, i_mul_b};
			end
		endcase
		prod = 34'(ma) * 34'(mb);
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n)
			o_mul_product <= 32'h0000_0000;
		else if (i_enable && i_mul_valid)
			o_mul_product <= prod[31:0];
	end

	// Result write to memory port
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_mem_wdata <= 16'h0000;
			o_mem_we <= 1'b0;
		end else if (i_enable) begin
			o_mem_we <= i_alu_valid && i_alu_cmd.to_mem;
			if (i_alu_valid && i_alu_cmd.to_mem)
				o_mem_wdata <= res;
		end
	end

	// Status flags; bus writes apply first, ALU events override
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			{half_carry, neg, ovf, zero, carry} <= 5'h00;
		end else if (i_enable) begin
			if (bus_ack && i_avs_write && i_avs_address == ADDR_STATUS) begin
				half_carry <= i_avs_writedata[BIT_HALF_CARRY];
				neg <= i_avs_writedata[BIT_NEG];
				ovf <= i_avs_writedata[BIT_OVF];
				zero <= i_avs_writedata[BIT_ZERO];
				carry <= i_avs_writedata[BIT_CARRY];
			end
			if (i_alu_valid) begin
				neg <= i_alu_cmd.byte_mode ? res[7] : res[15];
				if (res != 16'h0000)
					zero <= 1'b0;
				else if (is_arith)
					zero <= 1'b1;
				carry <= c_out;
				if (is_arith) begin
					half_carry <= c_half;
					ovf <= v_out;
				end
			end
		end
	end

	// Priority and control bits
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			prio <= 3'h0;
			prio_high <= 1'b0;
			pwin <= 1'b0;
		end else if (i_enable) begin
			if (bus_ack && i_avs_write && i_avs_address == ADDR_STATUS && !i_nesting_disable)
				prio <= i_avs_writedata[BIT_PRIO_HI:BIT_PRIO_LO];
			if (bus_ack && i_avs_write && i_avs_address == ADDR_CONTROL) begin
				if (!i_avs_writedata[BIT_PRIO_HIGH])
					prio_high <= 1'b0;
				pwin <= i_avs_writedata[BIT_PWIN];
			end
			// Interrupt controller load wins over software
			if (i_prio_load) begin
				prio <= i_prio_value[2:0];
				prio_high <= i_prio_value[3];
			end
		end
	end

	// Divider: 1 preload, 16 iterations, 1 step to DIV_FIX, 1 fixup with writeback = 19 cycles
	always_comb begin
		next_r = {div_r[15:0], div_q[31]};
		if (next_r >= {1'b0, div_d})
			next_r = next_r - {1'b0, div_d};
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			div_state <= DIV_IDLE;
			div_cnt <= 5'h00;
			div_q <= 32'h0000_0000;
			div_r <= 17'h0_0000;
			div_d <= 16'h0000;
			div_neg_q <= 1'b0;
			div_neg_r <= 1'b0;
			o_div_done <= 1'b0;
		end else if (i_enable) begin
			o_div_done <= 1'b0;
			case (div_state)
				DIV_IDLE: begin
					if (i_div_start) begin
						logic [31:0] dvd;
						logic [15:0] dvs;
						dvd = i_div_cmd.long_div
							? {wreg[{i_div_cmd.dividend_reg[3:1], 1'b1}], wreg[{i_div_cmd.dividend_reg[3:1], 1'b0}]}
							: {{16{i_div_cmd.is_signed & wreg[i_div_cmd.dividend_reg][15]}}, wreg[i_div_cmd.dividend_reg]};
						dvs = wreg[i_div_cmd.divisor_reg];
						div_neg_r <= i_div_cmd.is_signed && dvd[31];
						div_neg_q <= i_div_cmd.is_signed && (dvd[31] ^ dvs[15]);
						div_q <= (i_div_cmd.is_signed && dvd[31]) ? 32'(-dvd) : dvd;
						div_d <= (i_div_cmd.is_signed && dvs[15]) ? 16'(-dvs) : dvs;
						div_r <= 17'h0_0000;
						div_cnt <= 5'h00;
						div_state <= DIV_RUN;
					end
				end
				DIV_RUN: begin
					// Hold freezes between cycles so an interrupt can intervene
					if (!i_div_hold) begin
						if (div_cnt == 5'h00) begin
							div_r <= {1'b0, div_q[31:16]}; // Upper half preloads remainder
							div_q <= {div_q[15:0], 16'h0000};
						end else if (div_cnt <= DIV_ITER) begin
							div_r <= next_r;
							div_q <= {div_q[30:0], {div_r[15:0], div_q[31]} >= {1'b0, div_d}};
						end
						div_cnt <= div_cnt + 5'h01;
						if (div_cnt == DIV_ITER + 5'h01)
							div_state <= DIV_FIX;
					end
				end
				DIV_FIX: begin
					if (!i_div_hold) begin
						o_div_done <= 1'b1;
						div_state <= DIV_IDLE;
					end
				end
				default: div_state <= DIV_IDLE;
			endcase
		end
	end
	assign o_div_busy = (div_state != DIV_IDLE);

	// Working registers, written by decoder, ALU and divider
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (int k = 0; k < 16; k++)
				wreg[k] <= 16'h0000;
		end else if (i_enable) begin
			if (i_reg_we)
				wreg[i_reg_waddr] <= i_reg_wdata;
			if (i_alu_valid && !i_alu_cmd.to_mem) begin
				if (i_alu_cmd.byte_mode)
					wreg[i_alu_cmd.dst][7:0] <= res[7:0]; // byte writes keep the top byte
				else
					wreg[i_alu_cmd.dst] <= res;
			end
			if (div_state == DIV_FIX && !i_div_hold) begin
				wreg[0] <= div_neg_q ? 16'(-div_q[15:0]) : div_q[15:0];
				wreg[1] <= div_neg_r ? 16'(-div_r[15:0]) : div_r[15:0];
			end
		end
	end
	assign o_reg_dump = wreg[i_reg_dump_sel];

	// Avalon slave: one wait state, answer on the second cycle
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n)
			bus_ack <= 1'b0;
		else if (i_enable)
			bus_ack <= (i_avs_read || i_avs_write) && !bus_ack;
	end
	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !bus_ack;

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n)
			o_avs_readdata <= 32'h0000_0000;
		else if (i_enable && i_avs_read && !bus_ack) begin
			if (i_avs_address == ADDR_STATUS)
				o_avs_readdata <= {16'h0000, status_word};
			else if (i_avs_address == ADDR_CONTROL)
				o_avs_readdata <= {16'h0000, control_word};
			else if (i_avs_address == ADDR_DIVSTAT)
				o_avs_readdata <= {31'h0000_0000, o_div_busy};
			else
				o_avs_readdata <= 32'h0000_0000;
		end
	end

	prio_user_off_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		(o_cpu_priority[2:0] == PRIO_USER_OFF) |-> o_user_irq_off)
		else $error("priority 7 did not disable user interrupts");
	prio_locked_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		(i_enable && i_nesting_disable && !i_prio_load) |=> $stable(o_cpu_priority[2:0]))
		else $error("priority changed while nesting disabled");
	reserved_zero_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		(status_word[15:9] == 7'h00) && (control_word[1:0] == 2'b00))
		else $error("reserved bits not zero");
	zero_sticky_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		(i_enable && i_alu_valid && res != 16'h0000) |=> !zero)
		else $error("zero flag not cleared by nonzero result");
	neg_flag_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		(i_enable && i_alu_valid && !i_alu_cmd.byte_mode) |=> (neg == $past(res[15])))
		else $error("negative flag mismatch");
	mul_one_cycle_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		(i_enable && i_mul_valid && i_mul_mode == MUL_UU) |=> (o_mul_product == $past(i_mul_a) * $past(i_mul_b)))
		else $error("unsigned product wrong");
	div_length_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		(i_enable && !i_div_hold && div_state == DIV_IDLE && i_div_start) ##1 (i_enable && !i_div_hold)[*8]
		|-> o_div_busy)
		else $error("divider finished early");
	pwin_out_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		o_program_window == control_word[BIT_PWIN])
		else $error("window output disagrees with control");
	prio_high_clear_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		(i_enable && !i_prio_load && !o_cpu_priority[3]) |=> !o_cpu_priority[3])
		else $error("priority high bit set by software");
endmodule // cpu_alu_status_muldiv

// [alu_pkg.sv]
// Package for the CPU ALU, status flags, multiplier and divider.
// Assumes a single 25 MHz core clock and an Avalon-MM register master.
package alu_pkg;
	localparam logic [1:0]  ADDR_STATUS    = 2'h0;
	localparam logic [1:0]  ADDR_CONTROL   = 2'h1;
	localparam logic [1:0]  ADDR_DIVSTAT   = 2'h2;
	localparam int          BIT_HALF_CARRY = 8;
	localparam int          BIT_PRIO_HI    = 7;
	localparam int          BIT_PRIO_LO    = 5;
	localparam int          BIT_REPEAT     = 4;
	localparam int          BIT_NEG        = 3;
	localparam int          BIT_OVF        = 2;
	localparam int          BIT_ZERO       = 1;
	localparam int          BIT_CARRY      = 0;
	localparam int          BIT_PRIO_HIGH  = 3;
	localparam int          BIT_PWIN       = 2;
	localparam logic [15:0] STATUS_RESET   = 16'h0000;
	localparam logic [15:0] STATUS_WMASK   = 16'h01EF;
	localparam logic [15:0] CONTROL_MASK   = 16'h000C;
	localparam int          DIV_CYCLES     = 19;
	localparam logic [4:0]  DIV_ITER       = 5'h10;
	localparam logic [2:0]  PRIO_USER_OFF  = 3'h7;

	typedef enum logic [3:0] {
		OP_ADD = 4'h0, OP_ADC = 4'h1, OP_SUB = 4'h2, OP_SBB = 4'h3,
		OP_AND = 4'h4, OP_OR  = 4'h5, OP_XOR = 4'h6, OP_SL  = 4'h7,
		OP_LSR = 4'h8, OP_ASR = 4'h9, OP_MOV = 4'hA
	} alu_op_t;

	typedef enum logic [2:0] {
		MUL_SS = 3'h0, MUL_UU = 3'h1, MUL_SLIT = 3'h2, MUL_ULIT = 3'h3,
		MUL_US = 3'h4, MUL_BB = 3'h5
	} mul_mode_t;

	typedef enum logic [2:0] {
		DIV_IDLE = 3'b001, DIV_RUN = 3'b010, DIV_FIX = 3'b100
	} div_state_t;

	typedef struct packed {
		alu_op_t     op;
		logic        byte_mode;
		logic        from_mem;
		logic        to_mem;
		logic [3:0]  src_a;
		logic [3:0]  src_b;
		logic [3:0]  dst;
	} alu_cmd_t;

	typedef struct packed {
		logic        is_signed;
		logic        long_div;
		logic [3:0]  dividend_reg;
		logic [3:0]  divisor_reg;
	} div_cmd_t;
endpackage

// [decoder_model.sv]
// Decoder and working register model: loads registers and issues divides.
// Assumes one edge-driven caller at a time; signals change after rising edges.
module decoder_model
	import alu_pkg::*;
(
	input  wire logic        i_clock,
	output logic             o_reg_we,
	output logic [3:0]       o_reg_waddr,
	output logic [15:0]      o_reg_wdata,
	output logic             o_div_start,
	output div_cmd_t         o_div_cmd,
	output logic             o_div_hold
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		o_reg_we = 1'b0;
		o_reg_waddr = 4'h0;
		o_reg_wdata = 16'h0000;
		o_div_start = 1'b0;
		o_div_cmd = '0;
		o_div_hold = 1'b0;
	end

	task automatic write_reg(logic [3:0] a, logic [15:0] d);
		@(posedge i_clock);
		o_reg_we <= 1'b1;
		o_reg_waddr <= a;
		o_reg_wdata <= d;
		@(posedge i_clock);
		o_reg_we <= 1'b0;
		// Released data shows the inverse, never a stale match
		o_reg_wdata <= ~d;
	endtask

	task automatic divide(div_cmd_t c, logic [31:0] dvd, logic [15:0] dvs, int hold_at, int hold_len);
		write_reg(c.dividend_reg + 4'h1, dvd[31:16]);
		write_reg(c.dividend_reg, dvd[15:0]);
		write_reg(c.divisor_reg, dvs);
		@(posedge i_clock);
		o_div_start <= 1'b1;
		o_div_cmd <= c;
		@(posedge i_clock);
		o_div_start <= 1'b0;
		o_div_cmd <= div_cmd_t'(~c);
		repeat (hold_at) @(posedge i_clock);
		if (hold_len > 0) begin
			// Pause as an interrupt would, mid divide
			o_div_hold <= 1'b1;
			repeat (hold_len) @(posedge i_clock);
			o_div_hold <= 1'b0;
		end
	endtask
endmodule // decoder_model

// [cpu_alu_status_muldiv_bench.sv]
// Self-checking bench for the ALU, status and control registers, multiplier and divider.
// Assumes decoder_model drives the working register and divider command ports.
module cpu_alu_status_muldiv_bench import alu_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {string what; logic [31:0] exp; logic [31:0] mask;} note_t;
	note_t q[$];
	int mismatches = 0, check_count = 0, seed = 30, cyc = 0, div_cyc = 0;
	logic i_clock = 0, i_arst_n = 0, i_enable = 1, i_avs_read = 0, i_avs_write = 0;
	logic i_nesting_disable = 0, i_repeat_active = 0, i_prio_load = 0, i_alu_valid = 0;
	logic i_carry_in = 0, i_mul_valid = 0, mul_pend = 0, dump_pend = 0;
	logic [1:0] i_avs_address = 0;
	logic [31:0] i_avs_writedata = 0, o_avs_readdata, o_mul_product;
	logic [3:0] i_prio_value = 0, i_reg_dump_sel = 0, i_reg_waddr, o_cpu_priority;
	logic [15:0] i_mem_rdata = 0, i_mul_a = 0, i_mul_b = 0, i_reg_wdata, o_mem_wdata, o_reg_dump;
	alu_cmd_t i_alu_cmd = '0;
	mul_mode_t i_mul_mode = MUL_SS;
	div_cmd_t i_div_cmd;
	logic i_reg_we, i_div_start, i_div_hold, o_avs_waitrequest, o_mem_we;
	logic o_div_busy, o_div_done, o_user_irq_off, o_program_window;

	always #20 i_clock = ~i_clock;

	cpu_alu_status_muldiv i_cpu_alu_status_muldiv (.i_clock, .i_arst_n, .i_enable, .i_avs_address,
		.i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest,
		.i_nesting_disable, .i_repeat_active, .i_prio_load, .i_prio_value, .i_alu_valid, .i_alu_cmd,
		.i_carry_in, .i_mem_rdata, .o_mem_wdata, .o_mem_we, .i_mul_valid, .i_mul_mode, .i_mul_a,
		.i_mul_b, .o_mul_product, .i_div_start, .i_div_cmd, .i_div_hold, .i_reg_we, .i_reg_waddr,
		.i_reg_wdata, .o_reg_dump, .i_reg_dump_sel, .o_div_busy, .o_div_done, .o_cpu_priority,
		.o_user_irq_off, .o_program_window);
	decoder_model i_decoder_model (.i_clock, .o_reg_we(i_reg_we), .o_reg_waddr(i_reg_waddr),
		.o_reg_wdata(i_reg_wdata), .o_div_start(i_div_start), .o_div_cmd(i_div_cmd), .o_div_hold(i_div_hold));

	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic note(string what, logic [31:0] exp, logic [31:0] mask = 32'hFFFF_FFFF);
		q.push_back('{what, exp, mask});
	endtask
	task automatic take(logic [31:0] seen);
		note_t n;
		if (q.size() == 0) check("unexpected result", seen, 32'hXXXX_XXXX);
		else begin
			n = q.pop_front();
			check(n.what, seen & n.mask, n.exp & n.mask);
		end
	endtask

	// Results are sampled mid-cycle, away from the edge that makes them
	always @(negedge i_clock) begin
		if (i_avs_read && o_avs_waitrequest === 1'b0) take(o_avs_readdata);
		if (o_mem_we === 1'b1) take({16'h0000, o_mem_wdata});
		if (mul_pend) take(o_mul_product);
		if (o_div_done === 1'b1) take(32'(div_cyc));
		if (dump_pend) take({16'h0000, o_reg_dump});
	end
	always @(posedge i_clock) begin
		mul_pend <= i_mul_valid;
		div_cyc <= i_div_start ? 0 : div_cyc + 1;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			conclude();
		end
	end

	task automatic bus(logic wr, logic [1:0] a, logic [15:0] d);
		@(posedge i_clock);
		i_avs_read <= !wr;
		i_avs_write <= wr;
		i_avs_address <= a;
		i_avs_writedata <= {16'h0000, d};
		// Request stands until waitrequest is seen low at a rising edge
		do begin
			@(posedge i_clock);
		end while (o_avs_waitrequest !== 1'b0);
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
		i_avs_writedata <= ~{16'h0000, d};
	endtask
	task automatic wr(logic [1:0] a, logic [15:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(logic [1:0] a, logic [31:0] e, logic [31:0] m = 32'hFFFF_FFFF);
		note("register read", e, m);
		bus(1'b0, a, 16'h0000);
	endtask
	task automatic dump(logic [3:0] s, logic [15:0] e, logic [15:0] m, string w);
		note(w, {16'h0000, e}, {16'h0000, m});
		@(posedge i_clock);
		i_reg_dump_sel <= s;
		dump_pend <= 1'b1;
		@(posedge i_clock);
		dump_pend <= 1'b0;
	endtask

	task automatic alu(alu_op_t op, logic bm, logic [15:0] a, logic [15:0] b, logic ci, logic zp, logic mem);
		int w, aa, bx, r, hc, c, n, ov, z, cin, wm;
		logic arith, sub;
		if (mem) b = a;
		w = bm ? 8 : 16;
		wm = (1 << w) - 1;
		arith = op inside {OP_ADD, OP_ADC, OP_SUB, OP_SBB};
		sub = op inside {OP_SUB, OP_SBB};
		aa = a & wm;
		bx = (sub ? ~b : b) & wm;
		cin = (op == OP_SUB) ? 1 : (op == OP_ADC || op == OP_SBB) ? ci : 0;
		case (op)
			OP_AND: r = aa & bx;
			OP_OR: r = aa | bx;
			OP_XOR: r = aa ^ bx;
			OP_SL: r = aa << 1;
			OP_LSR: r = aa >> 1;
			OP_ASR: r = (aa >> 1) | (aa & (1 << (w - 1)));
			OP_MOV: r = bx;
			default: r = aa + bx + cin;
		endcase
		hc = ((aa & ((1 << (w / 2)) - 1)) + (bx & ((1 << (w / 2)) - 1)) + cin) >> (w / 2);
		c = (r >> w) & 1;
		if (op inside {OP_LSR, OP_ASR}) c = aa & 1;
		r = r & wm;
		n = r >> (w - 1);
		ov = ((aa >> (w - 1)) == (bx >> (w - 1))) && (n != (aa >> (w - 1)));
		z = (r == 0) && (arith || zp);
		i_decoder_model.write_reg(4'h1, a);
		i_decoder_model.write_reg(4'h2, b);
		wr(ADDR_STATUS, {14'h0000, zp, 1'b0});
		if (mem) note("memory write", r, wm);
		@(posedge i_clock);
		i_alu_valid <= 1'b1;
		i_alu_cmd <= '{op, bm, mem, mem, 4'h1, mem ? 4'h1 : 4'h2, 4'h3};
		i_carry_in <= ci;
		i_mem_rdata <= a;
		@(posedge i_clock);
		i_alu_valid <= 1'b0;
		i_carry_in <= ~ci;
		i_mem_rdata <= ~a;
		rd(ADDR_STATUS, (hc << 8) | (n << 3) | (ov << 2) | (z << 1) | c,
			arith ? 32'h010F : (op inside {OP_SL, OP_LSR, OP_ASR}) ? 32'h000B : 32'h000A);
		if (!mem) dump(4'h3, 16'(r), 16'(wm), "alu result");
	endtask

	task automatic mul(mul_mode_t m, logic [15:0] a, logic [15:0] b);
		longint x, y;
		x = (m == MUL_SS || m == MUL_SLIT) ? longint'($signed(a)) : longint'(a);
		y = (m == MUL_SS || m == MUL_US) ? longint'($signed(b)) : (m == MUL_SLIT || m == MUL_ULIT) ? longint'(b[4:0]) : longint'(b);
		if (m == MUL_BB) begin
			x = a[7:0];
			y = b[7:0];
		end
		note("product", 32'(x * y));
		@(posedge i_clock);
		i_mul_valid <= 1'b1;
		i_mul_mode <= m;
		i_mul_a <= a;
		i_mul_b <= b;
		@(posedge i_clock);
		i_mul_valid <= 1'b0;
		i_mul_a <= ~a;
		i_mul_b <= ~b;
	endtask

	task automatic div(logic sg, logic lg, int hold, int gap);
		div_cmd_t c;
		logic [15:0] lo, hi, dvs;
		longint nn, dd;
		int k;
		lo = 16'($random(seed));
		dvs = 16'($random(seed)) | 16'h0001;
		if (sg && dvs == 16'hFFFF) dvs = 16'h0007;
		// Upper half kept small enough that the quotient fits 16 bits
		hi = sg ? {16{lo[15]}} : 16'($random(seed)) % dvs;
		nn = lg ? (sg ? longint'($signed({hi, lo})) : longint'({hi, lo})) : (sg ? longint'($signed(lo)) : longint'(lo));
		dd = sg ? longint'($signed(dvs)) : longint'(dvs);
		k = $random(seed);
		c = '{sg, lg, 4'(((k & 3) + 1) * 2), 4'(14 + ((k >> 2) & 1))};
		note("divide cycles", 32'(DIV_CYCLES + hold + gap));
		i_decoder_model.divide(c, {hi, lo}, dvs, 4, hold);
		if (gap > 0) begin
			// Clock enable low freezes the divide like a stall
			i_enable <= 1'b0;
			repeat (gap) @(posedge i_clock);
			i_enable <= 1'b1;
		end
		while (o_div_busy !== 1'b0) begin
			@(negedge i_clock);
		end
		dump(4'h0, 16'(nn / dd), 16'hFFFF, "quotient");
		dump(4'h1, 16'(nn % dd), 16'hFFFF, "remainder");
	endtask

	initial begin
		repeat (2) @(posedge i_clock);
		i_arst_n <= 1'b1;
		@(posedge i_clock);
		for (int a = 0; a < 4; a++) rd(2'(a), 32'h0000_0000);
		$display("test reset values done");
		wr(ADDR_STATUS, 16'hFFFF);
		rd(ADDR_STATUS, {16'h0000, STATUS_WMASK});
		check("priority", 32'(o_cpu_priority), 32'h7);
		check("user irq off", 32'(o_user_irq_off), 32'h1);
		i_nesting_disable <= 1'b1;
		wr(ADDR_STATUS, 16'h0000);
		rd(ADDR_STATUS, 32'h0000_00E0);
		i_nesting_disable <= 1'b0;
		wr(ADDR_STATUS, 16'h0000);
		rd(ADDR_STATUS, 32'h0000_0000);
		i_repeat_active <= 1'b1;
		wr(ADDR_STATUS, 16'h0000);
		rd(ADDR_STATUS, 32'h0000_0010);
		i_repeat_active <= 1'b0;
		repeat (3) @(posedge i_clock);
		rd(ADDR_STATUS, 32'h0000_0000);
		$display("test status done");
		wr(ADDR_CONTROL, 16'hFFFF);
		rd(ADDR_CONTROL, 32'h0000_0004);
		check("program window", 32'(o_program_window), 32'h1);
		@(posedge i_clock);
		i_prio_load <= 1'b1;
		i_prio_value <= 4'hA;
		@(posedge i_clock);
		i_prio_load <= 1'b0;
		i_prio_value <= 4'h5;
		rd(ADDR_CONTROL, 32'h0000_000C);
		rd(ADDR_STATUS, 32'h0000_0040);
		check("priority", 32'(o_cpu_priority), 32'hA);
		check("user irq off", 32'(o_user_irq_off), 32'h1);
		wr(ADDR_CONTROL, 16'h0000);
		rd(ADDR_CONTROL, 32'h0000_0000);
		check("priority", 32'(o_cpu_priority), 32'h2);
		check("user irq off", 32'(o_user_irq_off), 32'h0);
		wr(ADDR_STATUS, 16'h0000);
		$display("test control done");
		alu(OP_ADD, 1'b0, 16'hFFFF, 16'h0001, 1'b0, 1'b0, 1'b0);
		alu(OP_SUB, 1'b1, 16'h0000, 16'h0001, 1'b0, 1'b0, 1'b0);
		for (int i = 0; i < 40; i++) alu(alu_op_t'(4'(i % 11)), 1'($random(seed)), 16'($random(seed)),
			16'($random(seed)), 1'($random(seed)), 1'($random(seed)), i % 5 == 0);
		$display("test alu done");
		for (int i = 0; i < 18; i++) mul(mul_mode_t'(3'(i % 6)), 16'($random(seed)), 16'($random(seed)));
		$display("test multiply done");
		for (int i = 0; i < 8; i++) div(i[0], i[1], i == 5 ? 3 : 0, i == 6 ? 2 : 0);
		$display("test divide done");
		repeat (3) @(posedge i_clock);
		check("pending results", 32'(q.size()), 32'h0);
		conclude();
	end
endmodule // cpu_alu_status_muldiv_bench
